// *** rtl/cmw_top.sv ***
// clock source, power mode, wake-up and clock-out control with apb registers
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "cmw_map.svh"
module cmw_top #(
	parameter int unsigned FAST_HALF = `CMW_HALF_CYC(`CMW_FAST_KHZ),
	parameter int unsigned XTAL_HALF = `CMW_HALF_CYC(`CMW_SLOW_KHZ),
	parameter int unsigned RC_HALF = `CMW_HALF_CYC(`CMW_SLOW_KHZ)
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [9:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// wake and event sources
	input wire logic [2:0] ext_irq_pin_i,
	input wire logic [7:0] port1_pin_i,
	input wire logic [3:0] periph_event_i,
	// clock enables and mode
	output cmw_pkg::cmw_clk_en_s clk_en_o,
	output cmw_pkg::cmw_osc_en_s osc_en_o,
	output cmw_pkg::cmw_mode_e mode_o,
	// clock-out pin
	output logic clock_out_pin_o,
	output logic clock_out_oe_n_o
);
	import cmw_pkg::*;
	localparam cmw_top_st_s RST_ST = '{
		mode: CMW_RUN,
		power_mode_control: `CMW_RST_POWER_MODE_CONTROL,
		clock_control_reg: cmw_clock_control_reg_s'(`CMW_RST_CLOCK_CONTROL_REG),
		p1wk: `CMW_RST_P1WK,
		output_clock_control: `CMW_RST_OUTPUT_CLOCK_CONTROL,
		irq_en: `CMW_RST_IRQEN,
		osc_en: '{fast: 1'b1, slow_crystal: 1'b1, slow_rc: 1'b0},
		oe_n: 1'b1,
		default: '0
	};
	cmw_top_st_s st, next_st;
	logic fast_tick;
	logic xtal_tick;
	logic rc_tick;
	logic osc_half;
	logic [7:0] idx;
	logic hit;
	logic acc;
	logic done;
	logic wr;
	logic [7:0] wdat;
	logic [2:0] ext_fall;
	logic p1_change;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic stop_block;
	logic stop_wake;
	logic idle_wake;
	logic [5:0] psc_limit;
	logic [7:0] rdat;
	cmw_clock_control_reg_s wcc;
	cmw_clock_control_reg_s ncc;

	// oscillators run from the register state, so stop halts them and clears their counts
	cmw_tick_div #(.HALF(FAST_HALF)) u_fast (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.run_i(st.osc_en.fast),
		.tick_o(fast_tick)
	);
	cmw_tick_div #(.HALF(XTAL_HALF)) u_xtal (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.run_i(st.osc_en.slow_crystal),
		.tick_o(xtal_tick)
	);
	cmw_tick_div #(.HALF(RC_HALF)) u_rc (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.run_i(st.osc_en.slow_rc),
		.tick_o(rc_tick)
	);
	cmw_clkout u_clkout (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.half_tick_i(st.clk_en.sys_half),
		.ratio_i(st.output_clock_control[2:0]),
		.pin_o(clock_out_pin_o)
	);

	// bus decode
	assign idx = paddr_i[9:2];
	assign hit = (idx == `CMW_IDX_POWER_MODE_CONTROL) || (idx == `CMW_IDX_P1WK) || (idx == `CMW_IDX_OUTPUT_CLOCK_CONTROL)
		|| (idx == `CMW_IDX_CLOCK_CONTROL_REG) || (idx == `CMW_IDX_IRQEN) || (idx == `CMW_IDX_FLAG)
		|| (idx == `CMW_IDX_AUX);
	assign acc = psel_i && penable_i && !st.pready;
	assign done = psel_i && penable_i && st.pready;
	assign wr = done && pwrite_i && hit;
	assign wdat = pwdata_i[7:0];
	assign wcc = cmw_clock_control_reg_s'(wdat);

	// events and wake conditions
	assign ext_fall = st.ext_q & ~ext_irq_pin_i;
	assign p1_change = |((port1_pin_i ^ st.p1_q) & st.p1wk);
	assign flag_set = {p1_change, periph_event_i, ext_fall};
	assign flag_clr = (wr && idx == `CMW_IDX_FLAG) ? wdat : 8'h00;
	assign stop_block = |(~ext_irq_pin_i & st.irq_en[2:0]);
	assign idle_wake = |(st.flag & st.irq_en);
	// timer and uart flags take no part in leaving stop
	assign stop_wake = (|(st.flag[2:0] & st.irq_en[2:0])) || st.flag[`CMW_FLAG_P1];

	// prescaler limit, kept in idle as well
	always_comb begin
		case (st.clock_control_reg.system_clock_divider)
			2'h0: psc_limit = 6'h3f;
			2'h1: psc_limit = 6'h0f;
			2'h2: psc_limit = 6'h03;
			default: psc_limit = 6'h00;
		endcase
	end
	// slow source follows the type bit; the fast one is always the fast oscillator u_fast
	assign osc_half = st.clock_control_reg.fast_source_select ? fast_tick
		: (st.clock_control_reg.slow_source_type ? rc_tick : xtal_tick);

	// guarded clock control update
	always_comb begin
		ncc = st.clock_control_reg;
		ncc.osc_gain = wcc.osc_gain;
		ncc.periph_clock_halt = wcc.periph_clock_halt;
		ncc.system_clock_divider = wcc.system_clock_divider;
		if (st.clock_control_reg.fast_source_select) begin
			ncc.slow_source_type = wcc.slow_source_type;
		end
		if (!st.clock_control_reg.fast_source_select) begin
			ncc.fast_osc_halt = wcc.fast_osc_halt;
		end
		if (!st.clock_control_reg.fast_osc_halt) begin
			ncc.fast_source_select = wcc.fast_source_select;
		end
		if (ncc.fast_osc_halt && ncc.fast_source_select) begin
			ncc.fast_osc_halt = st.clock_control_reg.fast_osc_halt;
			ncc.fast_source_select = st.clock_control_reg.fast_source_select;
		end
	end

	// read mux
	always_comb begin
		case (idx)
			`CMW_IDX_POWER_MODE_CONTROL: rdat = st.power_mode_control;
			`CMW_IDX_P1WK: rdat = st.p1wk;
			`CMW_IDX_OUTPUT_CLOCK_CONTROL: rdat = st.output_clock_control;
			`CMW_IDX_CLOCK_CONTROL_REG: rdat = st.clock_control_reg;
			`CMW_IDX_IRQEN: rdat = st.irq_en;
			`CMW_IDX_FLAG: rdat = st.flag;
			`CMW_IDX_AUX: rdat = {1'b0, st.mode, 3'h0, st.clkout_mode};
			default: rdat = 8'h00;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.ext_q = ext_irq_pin_i;
		next_st.p1_q = port1_pin_i;
		// apb: one wait cycle, answer taken from flops
		next_st.pready = acc;
		if (acc) begin
			next_st.prdata = {24'h000000, rdat};
			next_st.pslverr = !hit;
		end
		next_st.flag = (st.flag & ~flag_clr) | flag_set;
		if (wr) begin
			case (idx)
				`CMW_IDX_POWER_MODE_CONTROL: next_st.power_mode_control = wdat & `CMW_POWER_MODE_CONTROL_MASK;
				`CMW_IDX_P1WK: next_st.p1wk = wdat;
				`CMW_IDX_OUTPUT_CLOCK_CONTROL: next_st.output_clock_control = wdat;
				`CMW_IDX_CLOCK_CONTROL_REG: next_st.clock_control_reg = ncc;
				`CMW_IDX_IRQEN: next_st.irq_en = wdat;
				`CMW_IDX_AUX: next_st.clkout_mode = wdat[0];
				default: next_st.power_mode_control = st.power_mode_control;
			endcase
		end
		// power mode sequencing
		case (st.mode)
			CMW_RUN: begin
				if (st.power_mode_control[`CMW_POWER_MODE_CONTROL_STOP]) begin
					if (stop_block) begin
						next_st.power_mode_control[`CMW_POWER_MODE_CONTROL_STOP] = 1'b0;
					end else begin
						next_st.mode = CMW_STOP;
					end
				end else if (st.power_mode_control[`CMW_POWER_MODE_CONTROL_IDLE]) begin
					next_st.mode = CMW_IDLE;
				end
			end
			CMW_IDLE: begin
				if (idle_wake) begin
					next_st.mode = CMW_RUN;
					next_st.power_mode_control[`CMW_POWER_MODE_CONTROL_IDLE] = 1'b0;
				end
			end
			CMW_STOP: begin
				if (stop_wake) begin
					next_st.mode = CMW_RUN;
					next_st.power_mode_control[`CMW_POWER_MODE_CONTROL_IDLE] = 1'b0;
					next_st.power_mode_control[`CMW_POWER_MODE_CONTROL_STOP] = 1'b0;
				end
			end
			default: next_st.mode = CMW_RUN;
		endcase
		// oscillators: all halted in stop, fast one also by its halt bit
		next_st.osc_en.fast = !next_st.clock_control_reg.fast_osc_halt && next_st.mode != CMW_STOP;
		next_st.osc_en.slow_crystal = !next_st.clock_control_reg.slow_source_type
			&& next_st.mode != CMW_STOP;
		next_st.osc_en.slow_rc = next_st.clock_control_reg.slow_source_type && next_st.mode != CMW_STOP;
		// system clock prescaler
		next_st.clk_en.sys_half = 1'b0;
		if (osc_half && st.mode != CMW_STOP) begin
			if (st.psc_cnt >= psc_limit) begin
				next_st.psc_cnt = 6'h00;
				next_st.clk_en.sys_half = 1'b1;
			end else begin
				next_st.psc_cnt = st.psc_cnt + 6'h01;
			end
		end
		next_st.phase = st.phase ^ next_st.clk_en.sys_half;
		// rising edge of the system clock clocks the cpu and peripherals
		next_st.clk_en.cpu = next_st.clk_en.sys_half && !st.phase
			&& st.mode == CMW_RUN;
		next_st.clk_en.periph = next_st.clk_en.sys_half && !st.phase
			&& !(st.mode == CMW_IDLE && st.clock_control_reg.periph_clock_halt);
		next_st.oe_n = !st.clkout_mode;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st <= RST_ST;
		end else begin
			st <= next_st;
		end
	end

	assign prdata_o = st.prdata;
	assign pready_o = st.pready;
	assign pslverr_o = st.pslverr;
	assign clk_en_o = st.clk_en;
	assign osc_en_o = st.osc_en;
	assign mode_o = st.mode;
	assign clock_out_oe_n_o = st.oe_n;

	// checks
	property p_no_halt_and_fast;
		@(posedge sys_clk_i) disable iff (reset_i)
		!(st.clock_control_reg.fast_osc_halt && st.clock_control_reg.fast_source_select);
	endproperty
	a_no_halt_and_fast: assert property (p_no_halt_and_fast)
		else $error("fast halt and fast select both set");

	property p_halt_only_slow;
		@(posedge sys_clk_i) disable iff (reset_i)
		$changed(st.clock_control_reg.fast_osc_halt) |-> !$past(st.clock_control_reg.fast_source_select);
	endproperty
	a_halt_only_slow: assert property (p_halt_only_slow)
		else $error("fast halt changed outside slow mode");

	property p_type_only_fast;
		@(posedge sys_clk_i) disable iff (reset_i)
		$changed(st.clock_control_reg.slow_source_type) |-> $past(st.clock_control_reg.fast_source_select);
	endproperty
	a_type_only_fast: assert property (p_type_only_fast)
		else $error("slow type changed outside fast mode");

	property p_switch_slow;
		@(posedge sys_clk_i) disable iff (reset_i)
		$changed(st.clock_control_reg.fast_source_select) |-> !$past(st.clock_control_reg.fast_osc_halt);
	endproperty
	a_switch_slow: assert property (p_switch_slow)
		else $error("clock select changed with fast clock halted");

	sequence s_idle_write;
		st.mode == CMW_RUN && wr && idx == `CMW_IDX_POWER_MODE_CONTROL && wdat[`CMW_POWER_MODE_CONTROL_IDLE]
			&& !wdat[`CMW_POWER_MODE_CONTROL_STOP];
	endsequence
	property p_idle_entry;
		@(posedge sys_clk_i) disable iff (reset_i)
		s_idle_write |-> ##2 (mode_o == CMW_IDLE);
	endproperty
	a_idle_entry: assert property (p_idle_entry)
		else $error("idle not entered two cycles after request");

	property p_stop_blocked;
		@(posedge sys_clk_i) disable iff (reset_i)
		(st.mode == CMW_RUN && st.power_mode_control[`CMW_POWER_MODE_CONTROL_STOP] && stop_block)
			|=> (mode_o != CMW_STOP && !st.power_mode_control[`CMW_POWER_MODE_CONTROL_STOP]);
	endproperty
	a_stop_blocked: assert property (p_stop_blocked)
		else $error("stop entered while enabled pin low");

	property p_stop_holds;
		@(posedge sys_clk_i) disable iff (reset_i)
		(mode_o == CMW_STOP && !stop_wake) |=> (mode_o == CMW_STOP);
	endproperty
	a_stop_holds: assert property (p_stop_holds)
		else $error("stop left without pin wake-up");

	property p_stop_quiet;
		@(posedge sys_clk_i) disable iff (reset_i)
		(mode_o == CMW_STOP) [*2] |-> (osc_en_o == '0 && !clk_en_o.sys_half && !clk_en_o.cpu);
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("clock running in stop");

	property p_idle_periph_halt;
		@(posedge sys_clk_i) disable iff (reset_i)
		(mode_o == CMW_IDLE && st.clock_control_reg.periph_clock_halt) |=> !clk_en_o.periph;
	endproperty
	a_idle_periph_halt: assert property (p_idle_periph_halt)
		else $error("peripheral clock running in idle with halt set");

	property p_idle_cpu_off;
		@(posedge sys_clk_i) disable iff (reset_i)
		(mode_o == CMW_IDLE) |=> !clk_en_o.cpu;
	endproperty
	a_idle_cpu_off: assert property (p_idle_cpu_off)
		else $error("cpu clock running in idle");

	property p_wake_clears;
		@(posedge sys_clk_i) disable iff (reset_i)
		($past(mode_o) != CMW_RUN && mode_o == CMW_RUN) |-> (st.power_mode_control[1:0] == 2'h0);
	endproperty
	a_wake_clears: assert property (p_wake_clears)
		else $error("request bits still set after wake-up");

	property p_pin_enable;
		@(posedge sys_clk_i) disable iff (reset_i)
		##1 (clock_out_oe_n_o == !$past(st.clkout_mode));
	endproperty
	a_pin_enable: assert property (p_pin_enable)
		else $error("clock-out enable does not follow pin mode");
endmodule : cmw_top

// *** rtl/cmw_map.svh ***
// register map, reset values and timing counts of the clock mode and wake-up block
`ifndef CMW_MAP_SVH
`define CMW_MAP_SVH
`define CMW_IDX_POWER_MODE_CONTROL 8'h87
`define CMW_IDX_P1WK 8'h96
`define CMW_IDX_OUTPUT_CLOCK_CONTROL 8'ha6
`define CMW_IDX_CLOCK_CONTROL_REG 8'hd8
`define CMW_IDX_IRQEN 8'he0
`define CMW_IDX_FLAG 8'he1
`define CMW_IDX_AUX 8'he2
`define CMW_RST_POWER_MODE_CONTROL 8'h00
`define CMW_RST_CLOCK_CONTROL_REG 8'h67
`define CMW_RST_P1WK 8'h00
`define CMW_RST_OUTPUT_CLOCK_CONTROL 8'h00
`define CMW_RST_IRQEN 8'h00
`define CMW_POWER_MODE_CONTROL_MASK 8'h8f
`define CMW_POWER_MODE_CONTROL_IDLE 0
`define CMW_POWER_MODE_CONTROL_STOP 1
`define CMW_FLAG_P1 7
`define CMW_AUX_MODE_LSB 4
`define CMW_CLK_KHZ 50000
`define CMW_FAST_KHZ 3750
`define CMW_SLOW_KHZ 32
`define CMW_HALF_CYC(k) ((`CMW_CLK_KHZ / (2 * (k))) < 1 ? 1 : (`CMW_CLK_KHZ / (2 * (k))))
`endif

// *** rtl/cmw_pkg.sv ***
// types shared by the clock mode and wake-up block
package cmw_pkg;
	typedef enum logic [2:0] {
		CMW_RUN = 3'b001,
		CMW_IDLE = 3'b010,
		CMW_STOP = 3'b100
	} cmw_mode_e;
	typedef struct packed {
		logic slow_source_type;
		logic [1:0] osc_gain;
		logic periph_clock_halt;
		logic fast_osc_halt;
		logic fast_source_select;
		logic [1:0] system_clock_divider;
	} cmw_clock_control_reg_s;
	typedef struct packed {
		logic cpu;
		logic periph;
		logic sys_half;
	} cmw_clk_en_s;
	typedef struct packed {
		logic fast;
		logic slow_crystal;
		logic slow_rc;
	} cmw_osc_en_s;
	typedef struct packed {
		cmw_mode_e mode;
		logic [7:0] power_mode_control;
		cmw_clock_control_reg_s clock_control_reg;
		logic [7:0] p1wk;
		logic [7:0] output_clock_control;
		logic [7:0] irq_en;
		logic [7:0] flag;
		logic clkout_mode;
		logic [5:0] psc_cnt;
		logic phase;
		logic [2:0] ext_q;
		logic [7:0] p1_q;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		cmw_clk_en_s clk_en;
		cmw_osc_en_s osc_en;
		logic oe_n;
	} cmw_top_st_s;
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} cmw_div_st_s;
	typedef struct packed {
		logic [2:0] cnt;
		logic pin;
	} cmw_clkout_st_s;
endpackage : cmw_pkg

// *** rtl/cmw_tick_div.sv ***
// oscillator model: half-period tick pulses from the system clock
`timescale 1ns/1ps
module cmw_tick_div #(
	parameter int unsigned HALF = 6
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// control
	input wire logic run_i,
	// tick
	output logic tick_o
);
	import cmw_pkg::*;
	cmw_div_st_s st, next_st;
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!run_i) begin
			next_st.cnt = '0;
		end else if (st.cnt >= 16'(HALF - 1)) begin
			next_st.cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign tick_o = st.tick;
endmodule : cmw_tick_div

// *** rtl/cmw_clkout.sv ***
// clock-out waveform: ratio and duty counted in system clock half periods
`timescale 1ns/1ps
module cmw_clkout (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// system clock half-period tick and ratio code
	input wire logic half_tick_i,
	input wire logic [2:0] ratio_i,
	// pin level
	output logic pin_o
);
	import cmw_pkg::*;
	cmw_clkout_st_s st, next_st;
	logic [2:0] period;
	logic [2:0] high;
	always_comb begin
		case (ratio_i)
			3'h0: begin period = 3'h4; high = 3'h2; end
			3'h1: begin period = 3'h6; high = 3'h2; end
			3'h2: begin period = 3'h0; high = 3'h2; end
			3'h3: begin period = 3'h4; high = 3'h1; end
			3'h4: begin period = 3'h2; high = 3'h1; end
			3'h5: begin period = 3'h6; high = 3'h4; end
			3'h6: begin period = 3'h0; high = 3'h6; end
			default: begin period = 3'h4; high = 3'h3; end
		endcase
	end
	// period 0 stands for eight half periods, wrapping the 3-bit counter
	always_comb begin
		next_st = st;
		if (half_tick_i) begin
			// a count left past a shorter period by a code change wraps at once
			if (period != 3'h0 && ({1'b0, st.cnt} + 4'h1) >= {1'b0, period}) begin
				next_st.cnt = 3'h0;
			end else begin
				next_st.cnt = st.cnt + 3'h1;
			end
			next_st.pin = (next_st.cnt < high);
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign pin_o = st.pin;
	property p_full_rate_toggle;
		@(posedge sys_clk_i) disable iff (reset_i)
		// a code change may leave one tick without a toggle, so only a settled count
		(half_tick_i && ratio_i == 3'h4 && $stable(ratio_i) && st.cnt < 3'h2
			&& pin_o == (st.cnt == 3'h0)) |=> (pin_o != $past(pin_o));
	endproperty
	a_full_rate_toggle: assert property (p_full_rate_toggle)
		else $error("full rate clock-out did not toggle");
endmodule : cmw_clkout

// *** sim/cmw_pins_model.sv ***
// wake pin drivers and clock-out pad load for the clock mode bench
`timescale 1ns/1ps
module cmw_pins_model (
	// clock
	input wire logic sys_clk_i,
	// clock-out load
	input wire logic clock_out_pin_i,
	input wire logic clock_out_oe_n_i,
	// wake pins and pad level
	output logic [2:0] ext_irq_pin_o,
	output logic [7:0] port1_pin_o,
	output logic pad_o
);
	logic pad_last = 1'b0;
	initial begin
		ext_irq_pin_o = 3'h7;
		port1_pin_o = 8'h00;
	end
	// undriven pad flips each cycle so a stale level never passes for output
	always @(posedge sys_clk_i) begin
		pad_last <= pad_o;
	end
	assign pad_o = clock_out_oe_n_i ? ~pad_last : clock_out_pin_i;
	task automatic set_pins(input logic [2:0] ext, input logic [7:0] p1);
		@(posedge sys_clk_i);
		ext_irq_pin_o <= ext;
		port1_pin_o <= p1;
	endtask : set_pins
endmodule : cmw_pins_model

// *** sim/cmw_top_tb.sv ***
// self-checking bench for the clock mode and wake-up block
`timescale 1ns/1ps
`include "cmw_map.svh"
module cmw_top_tb;
	import cmw_pkg::*;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [9:0] paddr_i = 10'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic [2:0] ext_irq_pin;
	logic [7:0] port1_pin;
	logic [3:0] periph_event_i = 4'h0;
	cmw_clk_en_s clk_en_o;
	cmw_osc_en_s osc_en_o;
	cmw_mode_e mode_o;
	logic clock_out_pin_o;
	logic clock_out_oe_n_o;
	logic pad;
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [31:0] lfsr = 32'hdd35;
	logic [31:0] rd;
	logic err;
	logic [7:0] cc;
	logic [7:0] wv;
	int hi;
	int rises;
	int g;
	int per[8] = '{4, 6, 8, 4, 2, 6, 8, 4};
	int hgh[8] = '{2, 2, 2, 1, 1, 4, 6, 3};
	logic [7:0] seq[10] = '{8'h6f, 8'he7, 8'he3, 8'heb, 8'h6b, 8'hef, 8'he3, 8'hef, 8'h67,
		8'h67};
	always #10 sys_clk_i = ~sys_clk_i;
	cmw_top #(.FAST_HALF(2), .XTAL_HALF(3), .RC_HALF(4)) DUT (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .ext_irq_pin_i(ext_irq_pin),
		.port1_pin_i(port1_pin), .periph_event_i(periph_event_i), .clk_en_o(clk_en_o),
		.osc_en_o(osc_en_o), .mode_o(mode_o), .clock_out_pin_o(clock_out_pin_o),
		.clock_out_oe_n_o(clock_out_oe_n_o));
	cmw_pins_model pins (
		.sys_clk_i(sys_clk_i), .clock_out_pin_i(clock_out_pin_o),
		.clock_out_oe_n_i(clock_out_oe_n_o), .ext_irq_pin_o(ext_irq_pin),
		.port1_pin_o(port1_pin), .pad_o(pad));
	function automatic logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : rnd
	// per-bit write filter of the clock control register
	function automatic logic [7:0] cc_next(input logic [7:0] cur, input logic [7:0] w);
		logic [7:0] n;
		n = {cur[7], w[6:4], cur[3:2], w[1:0]};
		if (cur[2]) n[7] = w[7];
		if (!cur[2]) n[3] = w[3];
		if (!cur[3]) n[2] = w[2];
		if (n[3] && n[2]) n[3:2] = cur[3:2];
		return n;
	endfunction : cc_next
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			n_mismatch++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		lfsr = rnd(lfsr);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= {lfsr[31:8], d};
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", 32'h1, 32'h0);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string name);
		apb(1'b0, idx, 8'h00);
		chk(name, {24'h0, exp}, rd);
	endtask : rdc
	task automatic wait_mode(input cmw_mode_e m);
		int n;
		n = 0;
		while (mode_o !== m && n < 100) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk("mode", 32'(m), 32'(mode_o));
	endtask : wait_mode
	task automatic pulse_evt(input logic [3:0] e);
		@(posedge sys_clk_i);
		periph_event_i <= e;
		@(posedge sys_clk_i);
		periph_event_i <= 4'h0;
	endtask : pulse_evt
	// first pulse only seeds the previous level, then 24 half periods are counted
	task automatic meas();
		int n;
		logic prev;
		n = -1;
		hi = 0;
		rises = 0;
		prev = 1'b0;
		while (n < 24) begin
			@(posedge sys_clk_i);
			if (clk_en_o.sys_half === 1'b1) begin
				if (n >= 0) hi += int'(pad);
				if (n >= 0) rises += int'(pad & ~prev);
				prev = pad;
				n++;
			end
		end
	endtask : meas
	// cycles from one system clock half-period pulse to the next
	task automatic gap(output int cyc);
		cyc = 0;
		while (clk_en_o.sys_half !== 1'b1) @(posedge sys_clk_i);
		do begin
			@(posedge sys_clk_i);
			cyc++;
		end while (clk_en_o.sys_half !== 1'b1 && cyc < 300);
	endtask : gap
	initial begin
		#400_000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (5) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		chk("oe_n", 32'h1, 32'(clock_out_oe_n_o));
		rdc(`CMW_IDX_POWER_MODE_CONTROL, 8'h00, "power_mode_control");
		rdc(`CMW_IDX_CLOCK_CONTROL_REG, 8'h67, "clock_control_reg");
		rdc(`CMW_IDX_P1WK, 8'h00, "p1wk");
		rdc(`CMW_IDX_OUTPUT_CLOCK_CONTROL, 8'h00, "output_clock_control");
		apb(1'b0, 8'h10, 8'h00);
		chk("pslverr", 32'h1, 32'(err));
		wv = lfsr[7:0];
		apb(1'b1, `CMW_IDX_P1WK, wv);
		rdc(`CMW_IDX_P1WK, wv, "p1wk");
		cc = 8'h67;
		foreach (seq[i]) begin
			apb(1'b1, `CMW_IDX_CLOCK_CONTROL_REG, seq[i]);
			cc = cc_next(cc, seq[i]);
			rdc(`CMW_IDX_CLOCK_CONTROL_REG, cc, "clock_control_reg");
			chk("osc", {29'h0, ~cc[3], ~cc[7], cc[7]}, 32'(osc_en_o));
		end
		pulse_evt(4'h1);
		rdc(`CMW_IDX_FLAG, 8'h08, "flag");
		// peripheral halt set so idle must also stop the peripheral enable
		apb(1'b1, `CMW_IDX_CLOCK_CONTROL_REG, 8'h77);
		apb(1'b1, `CMW_IDX_FLAG, 8'hff);
		apb(1'b1, `CMW_IDX_IRQEN, 8'h01);
		apb(1'b1, `CMW_IDX_POWER_MODE_CONTROL, 8'h01);
		wait_mode(CMW_IDLE);
		hi = 0;
		repeat (8) begin
			@(posedge sys_clk_i);
			hi += int'(clk_en_o.cpu) + int'(clk_en_o.periph);
		end
		chk("cpu_periph_en", 32'h0, 32'(hi));
		pins.set_pins(3'b110, 8'h00);
		wait_mode(CMW_RUN);
		rdc(`CMW_IDX_POWER_MODE_CONTROL, 8'h00, "power_mode_control");
		// enabled pin still low, so the stop request must be dropped
		apb(1'b1, `CMW_IDX_POWER_MODE_CONTROL, 8'h02);
		repeat (4) @(posedge sys_clk_i);
		chk("mode", 32'(CMW_RUN), 32'(mode_o));
		rdc(`CMW_IDX_POWER_MODE_CONTROL, 8'h00, "power_mode_control");
		pins.set_pins(3'b111, 8'h00);
		apb(1'b1, `CMW_IDX_FLAG, 8'hff);
		apb(1'b1, `CMW_IDX_P1WK, 8'h01);
		apb(1'b1, `CMW_IDX_IRQEN, 8'h89);
		apb(1'b1, `CMW_IDX_POWER_MODE_CONTROL, 8'h02);
		wait_mode(CMW_STOP);
		chk("osc", 32'h0, 32'(osc_en_o));
		pulse_evt(4'h1);
		pins.set_pins(3'b111, 8'h02);
		repeat (10) @(posedge sys_clk_i);
		chk("mode", 32'(CMW_STOP), 32'(mode_o));
		pins.set_pins(3'b111, 8'h03);
		wait_mode(CMW_RUN);
		apb(1'b0, `CMW_IDX_FLAG, 8'h00);
		chk("p1flag", 32'h1, 32'(rd[7]));
		apb(1'b1, `CMW_IDX_AUX, 8'h01);
		repeat (2) @(posedge sys_clk_i);
		chk("oe_n", 32'h0, 32'(clock_out_oe_n_o));
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, `CMW_IDX_OUTPUT_CLOCK_CONTROL, 8'(c));
			meas();
			meas();
			chk("clk_high", 32'(24 * hgh[c] / per[c]), 32'(hi));
			chk("clk_rise", 32'(24 / per[c]), 32'(rises));
		end
		// fast ticks every 2 cycles, divided by 4, 16 and 64
		for (int d = 2; d >= 0; d--) begin
			apb(1'b1, `CMW_IDX_CLOCK_CONTROL_REG, 8'h74 | 8'(d));
			gap(g);
			gap(g);
			chk("half_gap", 32'(2 << (2 * (3 - d))), 32'(g));
		end
		// second reset in mid-run brings back fast mode and the reset register values
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		chk("mode", 32'(CMW_RUN), 32'(mode_o));
		chk("oe_n", 32'h1, 32'(clock_out_oe_n_o));
		chk("osc", 32'h6, 32'(osc_en_o));
		rdc(`CMW_IDX_CLOCK_CONTROL_REG, 8'h67, "clock_control_reg");
		rdc(`CMW_IDX_OUTPUT_CLOCK_CONTROL, 8'h00, "output_clock_control");
		end_sim();
	end
endmodule : cmw_top_tb
